// *** include/ipb_pkg.sv ***
// Constants and carrier types for the interleaved PCM bus control block.
// Assumes one 100 MHz system clock and an APB register port with 32-bit data.
package ipb_pkg;

  // Four framers can share one backplane bus.
  localparam int NUM_FR = 4;

  // Clock rates and the cycle count of one bit at the fastest shared rate.
  localparam int CLK_RATE_KHZ = 100000;
  localparam int BUS_RATE_KHZ = 8192;
  localparam int BIT_CYC = CLK_RATE_KHZ / BUS_RATE_KHZ;
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 1);

  // Register indices, whose byte address is four times the index; STAT_ADDR is a byte address.
  localparam logic [15:0] CTRL_IDX = 16'h00b5;
  localparam logic [15:0] FR_STRIDE_IDX = 16'h0100;
  localparam logic [15:0] STAT_ADDR = 16'h1000;

  // Field positions of the interleave control register.
  localparam int EN_BIT = 3;
  localparam int TYPE_BIT = 2;
  localparam int ROLE0_BIT = 1;
  localparam int ROLE1_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h0f;

  // Role codes, written as {role_select_bit1, role_select_bit0}.
  localparam logic [1:0] ROLE_SLAVE = 2'h0;
  localparam logic [1:0] ROLE_M2 = 2'h1;
  localparam logic [1:0] ROLE_M4 = 2'h2;

  // Cycles after a register write before the bus slots are settled, and the counter value at half a frame.
  localparam logic [9:0] SETTLE_CYC = 10'h3ff;
  localparam logic [9:0] HALF_FRAME = 10'h0200;

  // Byte pair that a framer's elastic store offers for one time slot.
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] sig;
  } ipb_pcm_s;

  // Drive of one framer's backplane data and signaling pins.
  typedef struct packed {
    logic pcm;
    logic sig;
    logic oe;
  } ipb_drv_s;

endpackage

// *** src/ipb_top.sv ***
// Interleave control for four framers sharing backplane PCM data and signaling buses.
// Assumes framer elastic stores on mclk that answer a slot request within ten cycles.
// Behaviour
// - With interleaving on, the framers' data and signaling merge onto one shared bus each.
// - At 4.096 MHz two framers share one bus.
// - At 8.192 MHz all four framers share one bus.
// - Type bit 0 interleaves on byte boundaries, 1 on frame boundaries.
// - Interleaving is active only while the enable bit is 1; writing 0 stops it.
// - Byte interleaving accepts framers whose line inputs have independent clocks.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module ipb_top (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // Framer elastic store side.
  input wire ipb_pkg::ipb_pcm_s fr_pcm [ipb_pkg::NUM_FR],
  output var logic [ipb_pkg::NUM_FR-1:0] fr_req,
  output var logic [4:0] fr_slot [ipb_pkg::NUM_FR],
  // Backplane pins.
  output var ipb_pkg::ipb_drv_s [ipb_pkg::NUM_FR-1:0] fr_drv,
  output var logic frame_sync
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  // Role field of a control byte; note the field bits sit in reverse order.
  function automatic logic [1:0] role_of(input logic [7:0] c);
    return {c[ipb_pkg::ROLE1_BIT], c[ipb_pkg::ROLE0_BIT]};
  endfunction
  // Owner check and time slot of a bus bit, returned as {mine, slot}.
  function automatic logic [5:0] slot_of(input logic [9:0] b, input logic [1:0] nl,
                                         input logic frm, input logic [1:0] ps);
    logic [6:0] byte_no;
    logic [1:0] mask;
    logic [1:0] owner;
    logic [4:0] ts;
    byte_no = b[9:3];
    mask = 2'((3'd1 << nl) - 3'd1);
    if (frm) begin
      owner = b[9:8];
      ts = b[7:3];
    end else begin
      owner = byte_no[1:0] & mask;
      ts = 5'(byte_no >> nl);
    end
    return {owner == ps, ts};
  endfunction
  // Address decode of the per-framer control registers, returned as {hit, framer}.
  function automatic logic [2:0] dec_addr(input logic [15:0] a);
    logic [2:0] res;
    res = 3'h0;
    for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
      if (a == 16'((ipb_pkg::CTRL_IDX + 16'(f) * ipb_pkg::FR_STRIDE_IDX) << 2)) begin
        res = {1'b1, 2'(f)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave.
  logic [7:0] ctrl_r [ipb_pkg::NUM_FR];
  logic [9:0] cfg_age_r;
  logic [1:0] nlog [ipb_pkg::NUM_FR];
  logic [1:0] pos [ipb_pkg::NUM_FR];
  logic [31:0] stat_word;
  logic [2:0] dec;
  logic setup;
  logic wr_take;
  assign dec = dec_addr(paddr);
  assign setup = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite;
  // Zero-wait answer: ready comes in the first access cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup && !pready;
      pslverr <= setup && !dec[2] && (paddr != ipb_pkg::STAT_ADDR);
      if (setup && dec[2]) begin
        prdata <= {24'h00_0000, ctrl_r[dec[1:0]]};
      end else if (setup && paddr == ipb_pkg::STAT_ADDR) begin
        prdata <= stat_word;
      end else if (setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Control writes keep only the four assigned bits, so upper bits read zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= '{default: ipb_pkg::CTRL_RST};
    end else if (wr_take && dec[2]) begin
      ctrl_r[dec[1:0]] <= pwdata[7:0] & ipb_pkg::CTRL_MASK;
    end
  end

  // Age of the configuration; slots are only collision free once it settles.
  always_ff @(posedge mclk) begin
    if (sys_rst || wr_take) begin
      cfg_age_r <= 10'h000;
    end else if (cfg_age_r != ipb_pkg::SETTLE_CYC) begin
      cfg_age_r <= cfg_age_r + 10'h001;
    end
  end

  // Status shows each framer's live sharing width and slot position.
  always_comb begin
    stat_word = 32'h0000_0000;
    for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
      stat_word[f*4 +: 4] = {nlog[f], pos[f]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus roles of each framer.
  // Enable gates sharing.
  // A framer shares only while its own and its master's enable bits are set.
  always_comb begin
    logic m4;
    logic m2;
    m4 = 1'b0;
    m2 = 1'b0;
    for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
      m4 = ctrl_r[0][ipb_pkg::EN_BIT] && role_of(ctrl_r[0]) == ipb_pkg::ROLE_M4;
      m2 = ctrl_r[f & 2][ipb_pkg::EN_BIT] && role_of(ctrl_r[f & 2]) == ipb_pkg::ROLE_M2;
      if (ctrl_r[f][ipb_pkg::EN_BIT] && m4) begin
        nlog[f] = 2'd2;
        pos[f] = 2'(f);
      end else if (ctrl_r[f][ipb_pkg::EN_BIT] && m2) begin
        nlog[f] = 2'd1;
        pos[f] = 2'(f & 1);
      end else begin
        nlog[f] = 2'd0;
        pos[f] = 2'd0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame timing shared by all framers, counted in 8.192 MHz bit times.
  logic [3:0] div_r;
  logic [9:0] cnt_r;
  logic bit_start;
  assign bit_start = (div_r == 4'h0);

  // Master frame timing.
  // One counter stands in for the master's sync, so slaves cannot drift from it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_r <= 4'h0;
      cnt_r <= 10'h000;
      frame_sync <= 1'b0;
    end else begin
      div_r <= (div_r == ipb_pkg::BIT_LAST) ? 4'h0 : div_r + 4'h1;
      if (div_r == ipb_pkg::BIT_LAST) begin
        cnt_r <= cnt_r + 10'h001;
      end
      frame_sync <= bit_start && cnt_r == 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slot ownership per framer.
  logic [9:0] bbit [ipb_pkg::NUM_FR];
  logic [ipb_pkg::NUM_FR-1:0] load_ev;
  logic [ipb_pkg::NUM_FR-1:0] shift_ev;
  logic [ipb_pkg::NUM_FR-1:0] req_ev;
  logic [5:0] cur_slot [ipb_pkg::NUM_FR];
  logic [5:0] nxt_slot [ipb_pkg::NUM_FR];
  // Byte or frame slots.
  // Slower buses step one bus bit every two or four counter bits.
  always_comb begin
    logic [9:0] amask;
    logic [9:0] wmask;
    logic al;
    amask = 10'h000;
    wmask = 10'h000;
    al = 1'b0;
    for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
      amask = 10'(3'd4 >> nlog[f]) - 10'h001;
      wmask = 10'((11'h100 << nlog[f]) - 11'h001);
      al = bit_start && (cnt_r & amask) == 10'h000;
      bbit[f] = cnt_r >> (2'd2 - nlog[f]);
      cur_slot[f] = slot_of(bbit[f], nlog[f], ctrl_r[f][ipb_pkg::TYPE_BIT], pos[f]);
      nxt_slot[f] = slot_of((bbit[f] + 10'h001) & wmask, nlog[f],
                            ctrl_r[f][ipb_pkg::TYPE_BIT], pos[f]);
      load_ev[f] = al && bbit[f][2:0] == 3'h0;
      shift_ev[f] = al && bbit[f][2:0] != 3'h0;
      req_ev[f] = al && bbit[f][2:0] == 3'h7 && nxt_slot[f][5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slot requests and serial drive.
  logic [7:0] pcm_sh_r [ipb_pkg::NUM_FR];
  logic [7:0] sig_sh_r [ipb_pkg::NUM_FR];
  // One-bit-early prefetch.
  // Asking one bit early lets each elastic store absorb its own line clock.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fr_req <= '0;
      fr_slot <= '{default: 5'h00};
    end else begin
      for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
        fr_req[f] <= req_ev[f];
        if (req_ev[f]) begin
          fr_slot[f] <= nxt_slot[f][4:0];
        end
      end
    end
  end

  // Merged shared drive.
  // Outside its slots a framer releases the pins so the tied bus has one driver.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fr_drv <= '0;
      pcm_sh_r <= '{default: 8'h00};
      sig_sh_r <= '{default: 8'h00};
    end else begin
      for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
        if (load_ev[f]) begin
          fr_drv[f].oe <= cur_slot[f][5];
          fr_drv[f].pcm <= cur_slot[f][5] && fr_pcm[f].data[7];
          fr_drv[f].sig <= cur_slot[f][5] && fr_pcm[f].sig[7];
          pcm_sh_r[f] <= cur_slot[f][5] ? {fr_pcm[f].data[6:0], 1'b0} : 8'h00;
          sig_sh_r[f] <= cur_slot[f][5] ? {fr_pcm[f].sig[6:0], 1'b0} : 8'h00;
        end else if (shift_ev[f]) begin
          fr_drv[f].pcm <= pcm_sh_r[f][7];
          fr_drv[f].sig <= sig_sh_r[f][7];
          pcm_sh_r[f] <= {pcm_sh_r[f][6:0], 1'b0};
          sig_sh_r[f] <= {sig_sh_r[f][6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic settled;
  assign settled = cfg_age_r == ipb_pkg::SETTLE_CYC;
  a_disable_standalone: assert property (
    (wr_take && dec == 3'h5 && !pwdata[ipb_pkg::EN_BIT]) |=> nlog[1] == 2'd0 && pos[1] == 2'd0)
    else $error("framer 1 still shares after its enable was cleared");
  a_pair_two_way: assert property (
    (ctrl_r[0] == 8'h0a && ctrl_r[1] == 8'h08) |-> nlog[1] == 2'd1 && pos[1] == 2'd1)
    else $error("two-way pair not formed");
  a_quad_four_way: assert property (
    ((ctrl_r[0] & 8'h0b) == 8'h09 && ctrl_r[3][ipb_pkg::EN_BIT]) |-> nlog[3] == 2'd2 && pos[3] == 2'd3)
    else $error("four-way bus position wrong");
  a_frame_half_split: assert property (
    (load_ev[1] && nlog[1] == 2'd1 && ctrl_r[1][ipb_pkg::TYPE_BIT] && cnt_r < ipb_pkg::HALF_FRAME)
    |=> !fr_drv[1].oe)
    else $error("slave drove the master's half frame");
  a_byte_alternate: assert property (
    (load_ev[0] && nlog[0] == 2'd1 && !ctrl_r[0][ipb_pkg::TYPE_BIT] && !bbit[0][3])
    |=> fr_drv[0].oe ##1 fr_drv[0].oe)
    else $error("master missed its even byte slot");
  a_pair_one_driver: assert property (
    (settled && nlog[0] == 2'd1 && nlog[1] == 2'd1) |-> $onehot0({fr_drv[1].oe, fr_drv[0].oe}))
    else $error("two drivers on a shared pair bus");
  a_quad_one_driver: assert property (
    (settled && nlog[0] == 2'd2 && nlog[1] == 2'd2 && nlog[2] == 2'd2 && nlog[3] == 2'd2)
    |-> $onehot0({fr_drv[3].oe, fr_drv[2].oe, fr_drv[1].oe, fr_drv[0].oe}))
    else $error("more than one driver on the four-way bus");
  a_standalone_drive: assert property (
    (load_ev[2] && nlog[2] == 2'd0) |=> fr_drv[2].oe && fr_drv[2].pcm == $past(fr_pcm[2].data[7]))
    else $error("standalone framer did not drive its own byte");
endmodule // ipb_top
`default_nettype wire

// *** verification/ipb_store_model.sv ***
// Elastic store model for four framers: answers slot requests with byte pairs.
// Assumes requests on mclk; framer 3 answers slowly, the rest promptly.
`timescale 1ns/100ps
`default_nettype none

module ipb_store_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Slot requests.
  input wire logic [ipb_pkg::NUM_FR-1:0] fr_req,
  input wire logic [4:0] fr_slot [ipb_pkg::NUM_FR],
  // Byte pairs offered back.
  output var ipb_pkg::ipb_pcm_s fr_pcm [ipb_pkg::NUM_FR]
);

  int cnt [ipb_pkg::NUM_FR];
  logic [4:0] slot_r [ipb_pkg::NUM_FR];

  ////////////////////////////////////////////////////////////////////////////
  // Enabled stores, common reference.
  // The old byte is inverted while the new one is fetched, so a late sample shows up.
  always_ff @(posedge mclk) begin
    for (int f = 0; f < ipb_pkg::NUM_FR; f++) begin
      if (sys_rst) begin
        cnt[f] <= 0;
        fr_pcm[f] <= '0;
      end else if (fr_req[f]) begin
        cnt[f] <= (f == 3) ? 8 : 2;
        slot_r[f] <= fr_slot[f];
        fr_pcm[f] <= ~fr_pcm[f];
      end else if (cnt[f] == 1) begin
        cnt[f] <= 0;
        fr_pcm[f].data <= {1'b1, 2'(f), slot_r[f]};
        fr_pcm[f].sig <= ~{1'b1, 2'(f), slot_r[f]};
      end else if (cnt[f] > 1) begin
        cnt[f] <= cnt[f] - 1;
      end
    end
  end

endmodule // ipb_store_model
`default_nettype wire

// *** verification/ipb_top_tb_top.sv ***
// Testbench for the interleave control block: registers, shared bus timing, serial data.
// Assumes the store model beside it and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end

module ipb_top_tb_top;

  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, frame_sync, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ipb_pkg::ipb_pcm_s fr_pcm [ipb_pkg::NUM_FR];
  logic [ipb_pkg::NUM_FR-1:0] fr_req, oe_v, mask;
  logic [4:0] fr_slot [ipb_pkg::NUM_FR];
  logic [4:0] last_slot;
  ipb_pkg::ipb_drv_s [ipb_pkg::NUM_FR-1:0] fr_drv;
  int n_errors = 0, total_checks = 0, run_len = 0, last_run = 0;

  ipb_top ipb_top_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fr_pcm(fr_pcm), .fr_req(fr_req), .fr_slot(fr_slot),
    .fr_drv(fr_drv), .frame_sync(frame_sync));
  ipb_store_model ipb_store_model_inst (.mclk(mclk), .sys_rst(sys_rst), .fr_req(fr_req),
    .fr_slot(fr_slot), .fr_pcm(fr_pcm));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Output enables gathered for the collision watch.
  always_comb begin
    for (int f = 0; f < 4; f++) oe_v[f] = fr_drv[f].oe;
  end

  // Latest slot of framer 0, its drive run length, and two drivers on one bus.
  always @(posedge mclk) begin
    if (fr_req[0]) last_slot <= fr_slot[0];
    if (fr_drv[0].oe === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) last_run <= run_len;
      run_len <= 0;
    end
    if (!sys_rst && $countones(oe_v & mask) > 1) `CHK("collision", 1'b0, 1'b1)
  end

  // Byte address of a framer's control register.
  function automatic logic [15:0] ca(input int f);
    return 16'h02d4 + 16'(f * 16'h0400);
  endfunction

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    if (k >= 16) `CHK("pready", 1'b1, 1'b0)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes all four control registers, then lets the slot plan settle.
  task automatic cfg(input logic [7:0] c0, c1, c2, c3, input logic [3:0] m);
    logic [7:0] v [4];
    v = '{c0, c1, c2, c3};
    mask <= 4'h0;
    for (int f = 0; f < 4; f++)
      apb(1'b1, ca(f), {24'h00_0000, v[f]});
    repeat (1023) @(posedge mclk);
    mask <= m;
  endtask

  task automatic stat(input logic [15:0] e);
    apb(1'b0, 16'h1000, 32'h0000_0000);
    `CHK("status", {16'h0000, e}, rd)
  endtask

  task automatic wait_oe(input logic v);
    int k;
    k = 0;
    while (fr_drv[0].oe !== v && k < 15000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 15000) `CHK("oe wait", 1'b1, 1'b0)
  endtask

  // Framer 0's next owned run: serial byte pair at bit centres and total length.
  task automatic run_chk(input int bc, input int len);
    logic [4:0] s;
    logic [7:0] pb, sb;
    wait_oe(1'b0);
    wait_oe(1'b1);
    s = last_slot;
    repeat (bc / 2) @(posedge mclk);
    for (int i = 7; i >= 0; i--) begin
      pb[i] = fr_drv[0].pcm;
      sb[i] = fr_drv[0].sig;
      repeat (bc) @(posedge mclk);
    end
    wait_oe(1'b0);
    @(posedge mclk);
    `CHK("pcm byte", {3'b100, s}, pb)
    `CHK("sig byte", ~{3'b100, s}, sb)
    `CHK("run length", len, last_run)
  endtask

  task automatic t_regs;
    apb(1'b0, ca(0), 32'h0000_0000);
    `CHK("ctl reset", 32'h0000_0000, rd)
    apb(1'b1, ca(1), 32'h0000_00f3);
    apb(1'b0, ca(1), 32'h0000_0000);
    `CHK("ctl upper bits", 32'h0000_0003, rd)
    apb(1'b0, 16'h0004, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, ca(1), 32'h0000_0000);
    $display("test regs done");
  endtask

  // Frame sync pulses one cycle, once per frame of 1024 fast bit times.
  task automatic t_sync;
    int k;
    k = 0;
    while (frame_sync !== 1'b1 && k < 15000) begin
      @(posedge mclk);
      k++;
    end
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (frame_sync !== 1'b1 && k < 15000);
    `CHK("frame period", 1024 * ipb_pkg::BIT_CYC, k)
    @(posedge mclk);
    `CHK("sync width", 1'b0, frame_sync)
    $display("test sync done");
  endtask

  task automatic t_quad;
    cfg(8'h09, 8'h08, 8'h08, 8'h08, 4'hf);
    stat(16'hba98);
    run_chk(12, 96);
    cfg(8'h0d, 8'h0c, 8'h0c, 8'h0c, 4'hf);
    run_chk(12, 3072);
    $display("test quad done");
  endtask

  task automatic t_pair;
    cfg(8'h0a, 8'h08, 8'h0a, 8'h08, 4'h3);
    stat(16'h5454);
    run_chk(24, 192);
    cfg(8'h0e, 8'h0c, 8'h0e, 8'h0c, 4'h3);
    run_chk(24, 6144);
    $display("test pair done");
  endtask

  task automatic t_off;
    cfg(8'h00, 8'h08, 8'h0a, 8'h08, 4'hc);
    stat(16'h5400);
    `CHK("own drive", 1'b1, fr_drv[0].oe)
    $display("test off done");
  endtask

  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog, well beyond the longest expected run.
  initial begin
    #900000;
    n_errors++;
    conclude;
  end

  // Reset for 16 cycles, then the scenarios.
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 51'h0};
    mask = 4'h0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs;
    t_sync;
    t_quad;
    t_pair;
    t_off;
    conclude;
  end

endmodule // ipb_top_tb_top
`default_nettype wire
